/* File: src/fsr_map.svh */
/*
  Named constants of the flash command sequencer: opcodes, parameter-table
  bytes, bit stepping and recovery timing.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// opcodes accepted while a write is suspended
`define FSR_OP_READ        8'h03
`define FSR_OP_FAST_READ   8'h0B
`define FSR_OP_READ_X2     8'hBB
`define FSR_OP_READ_X4     8'hEB
`define FSR_OP_READ_WORD   8'hE7
`define FSR_OP_READ_ID     8'h9F
`define FSR_OP_READ_QID    8'hAF
`define FSR_OP_READ_MFR    8'h90
`define FSR_OP_READ_STAT   8'h05
`define FSR_OP_READ_SEC    8'h2B
`define FSR_OP_READ_B1     8'hB1
`define FSR_OP_READ_C1     8'hC1
`define FSR_OP_PARAM_READ  8'h5A
`define FSR_OP_READ_LOCK   8'h3C
`define FSR_OP_RESUME      8'h30
`define FSR_OP_RST_ARM     8'h66
`define FSR_OP_RST_EXEC    8'h99
`define FSR_OP_BURST       8'hC0
`define FSR_OP_QUAD_ENTRY  8'h35
`define FSR_OP_QUAD_EXIT   8'hF5
`define FSR_OP_NOP         8'h00
`define FSR_OP_READ_ES     8'hAB
// opcodes refused while suspended
`define FSR_OP_WR_EN       8'h06
`define FSR_OP_WR_DIS      8'h04
`define FSR_OP_SUSPEND     8'hB0

// frame bit stepping (3-bit bit counters wrap at the byte boundary, the byte counter saturates)
`define FSR_STEP_SINGLE    3'h1
`define FSR_STEP_QUAD      3'h4
`define FSR_BYTE_LAST_ADDR 3'h3
`define FSR_BYTE_SAT       3'h7
`define FSR_OE_SINGLE      4'h2
`define FSR_OE_QUAD        4'hF

// parameter table contents
`define FSR_TB_BYTES       24
`define FSR_TB_PAD_ADDR    5'h1F
`define FSR_TB_SIG0        8'h53
`define FSR_TB_SIG1        8'h46
`define FSR_TB_SIG2        8'h44
`define FSR_TB_SIG3        8'h50
`define FSR_TB_REV_MINOR   8'h00
`define FSR_TB_REV_MAJOR   8'h01
`define FSR_TB_HDR_COUNT   8'h01
`define FSR_TB_UNUSED      8'hFF
`define FSR_TB_ID_STD      8'h00
`define FSR_TB_LEN_STD     8'h09
`define FSR_TB_PTR_STD     8'h30
`define FSR_TB_LEN_VND     8'h04
`define FSR_TB_PTR_VND     8'h60
`define FSR_TB_PTR_HI      8'h00

// software reset recovery
`define FSR_CLK_NS         40
`define FSR_RCV_PROG_US    100
`define FSR_RCV_OTHER_US   20
`define FSR_RCV_PROG_CYC   ((`FSR_RCV_PROG_US * 1000) / `FSR_CLK_NS)
`define FSR_RCV_OTHER_CYC  ((`FSR_RCV_OTHER_US * 1000) / `FSR_CLK_NS)

`endif

/* File: src/fsr_pkg.sv */
/*
  Types of the flash command sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fsr_pkg;
  // frame states, gray coded along idle-opcode-address-dummy-data
  typedef enum logic [2:0] {
    FSR_ST_IDLE  = 3'h0,
    FSR_ST_OPC   = 3'h1,
    FSR_ST_ADDR  = 3'h3,
    FSR_ST_DUMMY = 3'h2,
    FSR_ST_DATA  = 3'h6,
    FSR_ST_SKIP  = 3'h7
  } fsr_frame_t;
endpackage : fsr_pkg

/* File: src/fsr_rom_if.sv */
/*
  Read port between the sequencer and its parameter-table memory.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface fsr_rom_if;
  logic [4:0] addr;
  logic [7:0] data;
  modport host (output addr, input data);
  modport rom (input addr, output data);
endinterface : fsr_rom_if
`default_nettype wire

/* File: src/fsr_param_rom.sv */
/*
  Parameter-table memory: signature and two headers, registered read data.
  Assumes addresses past 31 are steered to the pad address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsr_map.svh"
module fsr_param_rom
  import fsr_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'hA5 // arbitrary value, not a real maker code
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  fsr_rom_if.rom rom_bus
);
  // byte order follows table address
  localparam logic [7:0] TABLE [`FSR_TB_BYTES] = '{
    `FSR_TB_SIG0, `FSR_TB_SIG1, `FSR_TB_SIG2, `FSR_TB_SIG3,
    `FSR_TB_REV_MINOR, `FSR_TB_REV_MAJOR, `FSR_TB_HDR_COUNT, `FSR_TB_UNUSED,
    `FSR_TB_ID_STD, `FSR_TB_REV_MINOR, `FSR_TB_REV_MAJOR, `FSR_TB_LEN_STD,
    `FSR_TB_PTR_STD, `FSR_TB_PTR_HI, `FSR_TB_PTR_HI, `FSR_TB_UNUSED,
    MFR_ID, `FSR_TB_REV_MINOR, `FSR_TB_REV_MAJOR, `FSR_TB_LEN_VND,
    `FSR_TB_PTR_VND, `FSR_TB_PTR_HI, `FSR_TB_PTR_HI, `FSR_TB_UNUSED
  };

  logic [7:0] data_r;
  assign rom_bus.data = data_r;

  // registered read; body tables live elsewhere, so past the headers reads blank
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      data_r <= `FSR_TB_UNUSED;
    end else if (rom_bus.addr < 5'(`FSR_TB_BYTES)) begin
      data_r <= TABLE[rom_bus.addr];
    end else begin
      data_r <= `FSR_TB_UNUSED;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_rom_signature:
    assert property (rom_bus.addr == 5'h00 |=> data_r == `FSR_TB_SIG0)
    else $error("signature byte wrong");
  chk_rom_ptr_std:
    assert property (rom_bus.addr == 5'h0C |=> data_r == `FSR_TB_PTR_STD)
    else $error("standard table pointer wrong");
endmodule : fsr_param_rom
`default_nettype wire

/* File: src/fsr_top.sv */
/*
  Serial flash command sequencer: suspend/resume, software reset, quad
  command mode exit and parameter-table read, behind the serial pins.
  Assumes the serial pins are asynchronous to clk_in and at least four
  clk_in cycles per serial clock phase; array timing lives outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsr_map.svh"
module fsr_top
  import fsr_pkg::*;
#(
  parameter logic [15:0] RCV_PROG_CYC = 16'(`FSR_RCV_PROG_CYC),
  parameter logic [15:0] RCV_OTHER_CYC = 16'(`FSR_RCV_OTHER_CYC),
  parameter logic [7:0] MFR_ID = 8'hA5 // arbitrary value, not a real maker code
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_out,
  input wire logic array_prog_start_in,
  input wire logic array_erase_start_in,
  input wire logic array_done_in,
  input wire logic perf_enhance_in,
  output logic write_enable_latch_out,
  output logic program_suspend_flag_out,
  output logic erase_suspend_flag_out,
  output logic four_line_command_mode_out,
  output logic busy_out,
  output logic array_hold_out,
  output logic array_abort_out
);
  fsr_rom_if rom_bus ();

  // pin synchroniser: three stages, a change counts once stages two and three agree
  logic [5:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r, pin_prev_r;
  // frame state
  fsr_frame_t state_r;
  logic [7:0] sh_r, opc_r, out_sh_r;
  logic [23:0] addr_r;
  logic [2:0] bit_cnt_r, byte_cnt_r, out_cnt_r;
  logic op_ok_r;
  logic [3:0] dq_r, dq_oe_r;
  // status
  logic wel_r, psb_r, esb_r, quad_r, arm_r, prog_run_r, erase_run_r;
  logic busy_r, hold_r, abort_r;
  logic [15:0] rcv_cnt_r;

  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic [3:0] dq_s;
  logic [2:0] step, bit_nxt;
  logic bit_last, susp, cmd_go, single, cmd_single, soft_rst_go;
  logic [7:0] in_byte, src;

  // only opcodes of the read, resume and reset families, burst, quad entry and exit and no-operation pass a suspend
  function automatic logic susp_ok(input logic [7:0] op);
    case (op)
      `FSR_OP_READ, `FSR_OP_FAST_READ, `FSR_OP_READ_X2, `FSR_OP_READ_X4,
      `FSR_OP_READ_WORD, `FSR_OP_READ_ID, `FSR_OP_READ_QID, `FSR_OP_READ_MFR,
      `FSR_OP_READ_STAT, `FSR_OP_READ_SEC, `FSR_OP_READ_B1, `FSR_OP_READ_C1,
      `FSR_OP_PARAM_READ, `FSR_OP_READ_LOCK, `FSR_OP_RESUME, `FSR_OP_RST_ARM,
      `FSR_OP_RST_EXEC, `FSR_OP_BURST, `FSR_OP_QUAD_ENTRY, `FSR_OP_QUAD_EXIT,
      `FSR_OP_NOP, `FSR_OP_READ_ES: susp_ok = 1'b1;
      default: susp_ok = 1'b0;
    endcase
  endfunction : susp_ok

  // synchroniser chain; only stage two reads stage one
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_s1_r <= 6'h3F;
      pin_s2_r <= 6'h3F;
      pin_s3_r <= 6'h3F;
      pin_f_r <= 6'h3F;
      pin_prev_r <= 6'h3F;
    end else begin
      pin_s1_r <= {dq_in, cs_n_in, sclk_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
      pin_prev_r <= pin_f_r;
    end
  end

  // pin events and command decode
  always_comb begin
    sclk_rise = pin_f_r[0] & ~pin_prev_r[0];
    sclk_fall = ~pin_f_r[0] & pin_prev_r[0];
    cs_fall = ~pin_f_r[1] & pin_prev_r[1];
    cs_rise = pin_f_r[1] & ~pin_prev_r[1];
    dq_s = pin_f_r[5:2];
    step = quad_r ? `FSR_STEP_QUAD : `FSR_STEP_SINGLE;
    bit_nxt = bit_cnt_r + step;
    bit_last = (bit_nxt == 3'h0);
    // single-line mode looks at the lowest line only; the upper ones are don't care
    in_byte = quad_r ? {sh_r[3:0], dq_s} : {sh_r[6:0], dq_s[0]};
    src = (out_cnt_r == 3'h0) ? rom_bus.data : out_sh_r;
    susp = psb_r | esb_r;
    // a command acts when chip select rises after its opcode byte
    cmd_go = cs_rise & op_ok_r & (~susp | susp_ok(opc_r));
    single = (byte_cnt_r == `FSR_STEP_SINGLE) & (bit_cnt_r == 3'h0);
    cmd_single = cmd_go & single;
    soft_rst_go = cmd_single & (opc_r == `FSR_OP_RST_EXEC) & arm_r;
  end

  // table reads past address 31 go to the pad address, which reads blank
  assign rom_bus.addr = (addr_r[23:5] == 19'h0_0000) ? addr_r[4:0] : `FSR_TB_PAD_ADDR;

  fsr_param_rom #(
    .MFR_ID(MFR_ID)
  ) u_rom (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .rom_bus(rom_bus)
  );

  // frame engine: shifts in opcode, address and dummy, shifts table bytes out
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= FSR_ST_IDLE;
      sh_r <= 8'h00;
      opc_r <= 8'h00;
      out_sh_r <= 8'h00;
      addr_r <= 24'h00_0000;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      out_cnt_r <= 3'h0;
      op_ok_r <= 1'b0;
      dq_r <= 4'h0;
      dq_oe_r <= 4'h0;
    end else if (cs_rise) begin
      state_r <= FSR_ST_IDLE;
      dq_oe_r <= 4'h0;
      dq_r <= 4'h0;
    end else if (cs_fall) begin
      state_r <= FSR_ST_OPC;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      out_cnt_r <= 3'h0;
      op_ok_r <= 1'b0;
      sh_r <= 8'h00;
    end else if (sclk_rise && state_r != FSR_ST_IDLE && state_r != FSR_ST_DATA) begin
      sh_r <= in_byte;
      bit_cnt_r <= bit_nxt;
      if (bit_last) begin
        if (byte_cnt_r != `FSR_BYTE_SAT) begin
          byte_cnt_r <= byte_cnt_r + `FSR_STEP_SINGLE;
        end
        case (state_r)
          FSR_ST_OPC: begin
            opc_r <= in_byte;
            op_ok_r <= 1'b1;
            // any opcode other than a parameter read simply skips the frame
            if (in_byte == `FSR_OP_PARAM_READ && (!susp || susp_ok(in_byte))) begin
              state_r <= FSR_ST_ADDR;
            end else begin
              state_r <= FSR_ST_SKIP;
            end
          end
          FSR_ST_ADDR: begin
            addr_r <= {addr_r[15:0], in_byte};
            if (byte_cnt_r == `FSR_BYTE_LAST_ADDR) begin
              state_r <= FSR_ST_DUMMY;
            end
          end
          FSR_ST_DUMMY: begin
            state_r <= FSR_ST_DATA;
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end
    end else if (sclk_fall && state_r == FSR_ST_DATA) begin
      // the rom answers a cycle after the pointer moves, well inside a serial phase
      dq_r <= quad_r ? src[7:4] : {2'b00, src[7], 1'b0};
      dq_oe_r <= quad_r ? `FSR_OE_QUAD : `FSR_OE_SINGLE;
      out_sh_r <= quad_r ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
      out_cnt_r <= out_cnt_r + step;
      if (out_cnt_r == 3'h0) begin
        addr_r <= addr_r + 24'h00_0001;
      end
    end
  end

  // volatile status; a software reset puts everything back to power-on values
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_rst_go) begin
      wel_r <= 1'b0;
      psb_r <= 1'b0;
      esb_r <= 1'b0;
      quad_r <= 1'b0;
      arm_r <= 1'b0;
      prog_run_r <= 1'b0;
      erase_run_r <= 1'b0;
    end else begin
      // completion only counts while the array is really running; a start landing
      // in the same cycle is dropped, since a start needs both run flags already clear
      if (array_done_in && !susp) begin
        prog_run_r <= 1'b0;
        erase_run_r <= 1'b0;
      end
      if (array_prog_start_in && !prog_run_r && !erase_run_r) begin
        prog_run_r <= 1'b1;
      end
      if (array_erase_start_in && !prog_run_r && !erase_run_r && !array_prog_start_in) begin
        erase_run_r <= 1'b1;
      end
      if (cmd_go) begin
        // arming survives only until the very next accepted command
        arm_r <= cmd_single && opc_r == `FSR_OP_RST_ARM;
        if (single) begin
          case (opc_r)
            `FSR_OP_WR_EN: wel_r <= 1'b1;
            `FSR_OP_WR_DIS: wel_r <= 1'b0;
            `FSR_OP_SUSPEND: begin
              if (prog_run_r && !susp) begin
                psb_r <= 1'b1;
                wel_r <= 1'b0;
              end else if (erase_run_r && !susp) begin
                esb_r <= 1'b1;
                wel_r <= 1'b0;
              end
            end
            `FSR_OP_RESUME: begin
              // no write enable needed; blocked while the enhance mode holds
              if (susp && !perf_enhance_in) begin
                psb_r <= 1'b0;
                esb_r <= 1'b0;
              end
            end
            `FSR_OP_QUAD_ENTRY: quad_r <= 1'b1;
            `FSR_OP_QUAD_EXIT: quad_r <= 1'b0;
            default: quad_r <= quad_r; // no-operation and reads leave status alone
          endcase
        end
      end
    end
  end

  // reset recovery: longer when a program was cut short
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rcv_cnt_r <= 16'h0000;
    end else if (soft_rst_go) begin
      rcv_cnt_r <= prog_run_r ? RCV_PROG_CYC : RCV_OTHER_CYC;
    end else if (rcv_cnt_r != 16'h0000) begin
      rcv_cnt_r <= rcv_cnt_r - 16'h0001;
    end
  end

  // registered array-facing outputs and busy
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy_r <= 1'b0;
      hold_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      busy_r <= ((prog_run_r | erase_run_r) & ~susp) | (rcv_cnt_r != 16'h0000);
      hold_r <= susp;
      abort_r <= soft_rst_go & (prog_run_r | erase_run_r);
    end
  end

  assign dq_out = dq_r;
  assign dq_oe_out = dq_oe_r;
  assign write_enable_latch_out = wel_r;
  assign program_suspend_flag_out = psb_r;
  assign erase_suspend_flag_out = esb_r;
  assign four_line_command_mode_out = quad_r;
  assign busy_out = busy_r;
  assign array_hold_out = hold_r;
  assign array_abort_out = abort_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_susp_wel_clear:
    assert property ($rose(psb_r) |-> !wel_r)
    else $error("write enable still set at suspend");
  chk_psb_set:
    assert property (cmd_single && opc_r == `FSR_OP_SUSPEND && prog_run_r && !susp
                     |=> psb_r ##1 hold_r)
    else $error("program suspend flag not set");
  chk_psb_clear:
    assert property (cmd_single && opc_r == `FSR_OP_RESUME && psb_r && !perf_enhance_in
                     |=> !psb_r ##1 busy_r == prog_run_r)
    else $error("program suspend flag not cleared on resume");
  chk_resume_no_wel:
    assert property (cmd_single && opc_r == `FSR_OP_RESUME && susp && !wel_r
                     && !perf_enhance_in |=> !psb_r && !esb_r)
    else $error("resume refused without write enable");
  chk_resume_perf:
    assert property (cmd_single && opc_r == `FSR_OP_RESUME && susp && perf_enhance_in
                     |=> psb_r || esb_r)
    else $error("resume taken in enhance mode");
  chk_nop_disarm:
    assert property (cmd_single && opc_r == `FSR_OP_NOP |=> !arm_r && $stable(wel_r)
                     && $stable(quad_r))
    else $error("no-operation did more than disarm");
  chk_arm_cancel:
    assert property (cmd_go && opc_r != `FSR_OP_RST_ARM |=> !arm_r)
    else $error("reset arm survived another command");
  chk_reset_clear:
    assert property (soft_rst_go |=> !wel_r && !psb_r && !esb_r && !quad_r ##1 busy_r)
    else $error("software reset left volatile state");
  chk_reset_abort:
    assert property (soft_rst_go && (prog_run_r || erase_run_r) |=> array_abort_out)
    else $error("operation not aborted by reset");
  chk_rcv_prog:
    assert property (soft_rst_go && prog_run_r |=> rcv_cnt_r == RCV_PROG_CYC)
    else $error("program recovery length wrong");
  chk_quad_exit:
    assert property (cmd_single && opc_r == `FSR_OP_QUAD_EXIT |=> !quad_r)
    else $error("quad exit ignored");
  chk_cs_end_drive:
    assert property (cs_rise |=> dq_oe_r == 4'h0 && state_r == FSR_ST_IDLE)
    else $error("output driven after chip select rose");
  chk_refused_still:
    assert property (cs_rise && op_ok_r && susp && !susp_ok(opc_r)
                     |=> $stable(wel_r) && $stable(psb_r) && $stable(esb_r) && $stable(arm_r))
    else $error("refused command changed state");
  chk_esb_set:
    assert property (cmd_single && opc_r == `FSR_OP_SUSPEND && erase_run_r && !prog_run_r
                     && !susp |=> esb_r)
    else $error("erase suspend flag not set");
endmodule : fsr_top
`default_nettype wire

/* File: tb/fsr_host.sv */
/*
  Host model of the serial link: drives chip select, link clock and data one frame at a time.
  Assumes the bench clk_in at 40 ns; four clk_in cycles make one link clock phase (160 ns).
*/
`timescale 1ns/1ps
`default_nettype none
module fsr_host (
  input wire logic clk_in,
  input wire logic [3:0] dq_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] dq_out
);
  // link clock and chip select idle high, data lines low; the link clock stands still between frames
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    dq_out = 4'h0;
  end
  // changes land just after a clock edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // one byte msb first; single-line keeps the upper lines noisy on purpose
  task automatic xfer(input logic [7:0] b, input logic q, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      sclk_out = 1'b0;
      dq_out = q ? b[7-4*i -: 4] : {{3{~b[7-i]}}, b[7-i]};
      tick(4);
      sclk_out = 1'b1;
      tick(3);
      r = q ? {r[3:0], dq_in} : {r[6:0], dq_in[1]};
      tick(1);
    end
  endtask : xfer
  task automatic open_f();
    tick(1);
    cs_n_out = 1'b0;
    tick(4);
  endtask : open_f
  // released data shows the inverse so a stale value never passes
  task automatic close_f(input int gap);
    tick(4);
    cs_n_out = 1'b1;
    dq_out = ~dq_out;
    tick(gap);
  endtask : close_f
  // one opcode alone in its frame, then the chip select high gap
  task automatic cmd(input logic [7:0] op, input logic q);
    logic [7:0] r;
    open_f();
    xfer(op, q, r);
    close_f(12);
  endtask : cmd
  // latency waits of the host after a suspend and after an operation completes
  task automatic wait_us(input int n);
    tick(n * 25);
  endtask : wait_us
endmodule : fsr_host
`default_nettype wire

/* File: tb/fsr_top_tb.sv */
/*
  Self-checking bench of the command sequencer, driving it through the host model.
  Assumes small recovery counts so that reset recovery fits in short bounded loops.
*/
`timescale 1ns/1ps
`default_nettype none
module fsr_top_tb;
  localparam logic [7:0] MFR = 8'h5E; // arbitrary value
  logic clk_in;
  logic rst;
  logic perf;
  logic [2:0] arr;
  logic sclk, cs_n, write_enable_latch, program_suspend_flag, erase_suspend_flag, quad, busy, hold, abort;
  logic [3:0] hdq, ddq, oe;
  wire logic [3:0] line;
  int miscompares = 0;
  int tests_run = 0;
  int aborts = 0;
  int cp, co;
  logic [7:0] r;
  logic [7:0] exp_t [0:24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    MFR, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF, 8'hFF};
  // each data line carries whoever enables it
  assign line = (oe & ddq) | (~oe & hdq);
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // abort is a one-cycle pulse, so it is counted where it stands
  always @(posedge clk_in) begin
    if (abort === 1'b1) aborts++;
  end
  fsr_host i_fsr_host (.clk_in(clk_in), .dq_in(line), .sclk_out(sclk), .cs_n_out(cs_n),
    .dq_out(hdq));
  fsr_top #(.RCV_PROG_CYC(16'h0014), .RCV_OTHER_CYC(16'h0005), .MFR_ID(MFR)) i_fsr_top (
    .clk_in(clk_in), .sys_rst_in(rst), .sclk_in(sclk), .cs_n_in(cs_n), .dq_in(line),
    .dq_out(ddq), .dq_oe_out(oe), .array_prog_start_in(arr[0]),
    .array_erase_start_in(arr[1]), .array_done_in(arr[2]), .perf_enhance_in(perf),
    .write_enable_latch_out(write_enable_latch), .program_suspend_flag_out(program_suspend_flag),
    .erase_suspend_flag_out(erase_suspend_flag), .four_line_command_mode_out(quad), .busy_out(busy),
    .array_hold_out(hold), .array_abort_out(abort));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h want %h", $time, g, e);
      miscompares++;
    end
  endtask : chk
  // order: write enable, program suspend, erase suspend, four-line mode
  task automatic flags(input logic [3:0] e);
    chk({4'h0, write_enable_latch, program_suspend_flag, erase_suspend_flag, quad}, {4'h0, e});
  endtask : flags
  task automatic apulse(input logic [2:0] m);
    i_fsr_host.tick(1);
    arr = m;
    i_fsr_host.tick(1);
    arr = 3'h0;
    i_fsr_host.tick(3);
  endtask : apulse
  // arm then execute, counting how long busy stands during recovery
  task automatic rst_cnt(input logic q, output int n);
    logic [7:0] x;
    i_fsr_host.cmd(8'h66, q);
    i_fsr_host.open_f();
    i_fsr_host.xfer(8'h99, q, x);
    i_fsr_host.close_f(0);
    n = 0;
    for (int i = 0; i < 300; i++) begin
      i_fsr_host.tick(1);
      if (busy === 1'b1) n++;
    end
  endtask : rst_cnt
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    rst = 1'b1;
    perf = 1'b0;
    arr = 3'h0;
    repeat (4) @(posedge clk_in);
    #1;
    rst = 1'b0;
    i_fsr_host.tick(4);
    flags(4'h0);
    // table read from address zero, one byte past the end
    i_fsr_host.open_f();
    i_fsr_host.xfer(8'h5A, 1'b0, r);
    for (int i = 0; i < 4; i++) i_fsr_host.xfer(8'h00, 1'b0, r);
    for (int i = 0; i < 25; i++) begin
      i_fsr_host.xfer(8'h00, 1'b0, r);
      chk(r, exp_t[i]);
      chk({4'h0, oe}, 8'h02);
    end
    i_fsr_host.close_f(12);
    chk({4'h0, oe}, 8'h00);
    // four-line mode; an intervening no-operation disarms the reset
    i_fsr_host.cmd(8'h35, 1'b0);
    flags(4'h1);
    i_fsr_host.cmd(8'h66, 1'b1);
    i_fsr_host.cmd(8'h00, 1'b1);
    i_fsr_host.cmd(8'h99, 1'b1);
    flags(4'h1);
    // table read in four-line mode, starting at the second header
    i_fsr_host.open_f();
    i_fsr_host.xfer(8'h5A, 1'b1, r);
    i_fsr_host.xfer(8'h00, 1'b1, r);
    i_fsr_host.xfer(8'h00, 1'b1, r);
    i_fsr_host.xfer(8'h10, 1'b1, r);
    i_fsr_host.xfer(8'h00, 1'b1, r);
    for (int i = 16; i < 18; i++) begin
      i_fsr_host.xfer(8'h00, 1'b1, r);
      chk(r, exp_t[i]);
      chk({4'h0, oe}, 8'h0F);
    end
    i_fsr_host.close_f(12);
    chk({4'h0, oe}, 8'h00);
    i_fsr_host.cmd(8'hF5, 1'b1);
    flags(4'h0);
    // program suspend, refused command, blocked and plain resume
    i_fsr_host.cmd(8'h06, 1'b0);
    apulse(3'h1);
    chk({7'h0, busy}, 8'h01);
    i_fsr_host.cmd(8'hB0, 1'b0);
    flags(4'h4);
    chk({6'h0, hold, busy}, 8'h02);
    i_fsr_host.wait_us(18);
    i_fsr_host.cmd(8'h06, 1'b0);
    flags(4'h4);
    perf = 1'b1;
    i_fsr_host.cmd(8'h30, 1'b0);
    flags(4'h4);
    perf = 1'b0;
    i_fsr_host.cmd(8'h30, 1'b0);
    flags(4'h0);
    chk({6'h0, hold, busy}, 8'h01);
    apulse(3'h4);
    chk({7'h0, busy}, 8'h00);
    // erase suspend and resume
    i_fsr_host.wait_us(1000);
    apulse(3'h2);
    i_fsr_host.cmd(8'hB0, 1'b0);
    flags(4'h2);
    i_fsr_host.wait_us(18);
    i_fsr_host.cmd(8'h30, 1'b0);
    flags(4'h0);
    apulse(3'h4);
    // software reset over a running program, then over an idle device
    i_fsr_host.cmd(8'h35, 1'b0);
    i_fsr_host.cmd(8'h06, 1'b1);
    apulse(3'h1);
    flags(4'h9);
    rst_cnt(1'b1, cp);
    flags(4'h0);
    chk(8'(aborts), 8'h01);
    rst_cnt(1'b0, co);
    chk(8'(aborts), 8'h01);
    chk({7'h0, cp > co}, 8'h01);
    chk(8'(co), 8'h05);
    chk({7'h0, cp >= 20}, 8'h01);
    stop_test();
  end
endmodule : fsr_top_tb
`default_nettype wire
